// >>> mise_pkg.sv
// Purpose: constants and types for the instruction subset execution unit
// Assumes: one system clock, registers reached over apb
// Notes:   register offsets are byte addresses of aligned 32-bit words
package mise_pkg;
  localparam int          MISE_PC_W      = 12;
  localparam int          MISE_RAM_D     = 160;
  localparam int          MISE_STK_D     = 6;
  localparam logic [11:0] MISE_OFF_INSTR = 12'h000;
  localparam logic [11:0] MISE_OFF_ACC   = 12'h004;
  localparam logic [11:0] MISE_OFF_STAT  = 12'h008;
  localparam logic [11:0] MISE_OFF_PC    = 12'h00c;
  localparam logic [11:0] MISE_OFF_MADDR = 12'h010;
  localparam logic [11:0] MISE_OFF_MDATA = 12'h014;
  localparam logic [11:0] MISE_OFF_CTRL  = 12'h018;
  localparam logic [7:0]  MISE_ACC_RST   = 8'h00;
  localparam logic [11:0] MISE_PC_RST    = 12'h000;
  localparam int          MISE_ST_Z      = 0;
  localparam int          MISE_ST_C      = 1;
  localparam int          MISE_ST_PD     = 2;
  localparam int          MISE_ST_TO     = 3;
  localparam int          MISE_ST_GIE    = 4;
  localparam int          MISE_ST_HALT   = 5;
  localparam int          MISE_ST_BUSY   = 6;
  localparam int          MISE_RET_CYC   = 2;
  typedef enum logic [4:0] {
    MISE_OP_NOP   = 5'h00, MISE_OP_HALT = 5'h01, MISE_OP_INC   = 5'h02, MISE_OP_INCREMENT_INTO_ACCUMULATOR = 5'h03,
    MISE_OP_JMP   = 5'h04, MISE_OP_MOVAM = 5'h05, MISE_OP_MOVAX = 5'h06, MISE_OP_MOVMA = 5'h07,
    MISE_OP_ORAM  = 5'h08, MISE_OP_ORAX = 5'h09, MISE_OP_ORM   = 5'h0a, MISE_OP_RET  = 5'h0b,
    MISE_OP_RETAX = 5'h0c, MISE_OP_INTERRUPT_RETURN = 5'h0d, MISE_OP_RL    = 5'h0e, MISE_OP_RLA  = 5'h0f,
    MISE_OP_RLC   = 5'h10, MISE_OP_ROTATE_LEFT_CARRY_INTO_ACC = 5'h11, MISE_OP_RR    = 5'h12, MISE_OP_RRA  = 5'h13,
    MISE_OP_RRC   = 5'h14, MISE_OP_CALL = 5'h15
  } mise_op_t;
  typedef enum logic [2:0] {
    MISE_S_IDLE = 3'b001,
    MISE_S_RET2 = 3'b010,
    MISE_S_HALT = 3'b100
  } mise_state_t;
  typedef struct packed {
    logic [4:0]  op;
    logic [11:0] addr;
    logic [7:0]  imm;
  } mise_instr_t;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] mem;
    logic       mem_we;
    logic       acc_we;
    logic       z_we;
    logic       z;
    logic       c_we;
    logic       c;
  } mise_res_t;
endpackage

// >>> mise_core.sv
// Purpose: executes a subset of an 8-bit core's instructions written over apb
// Assumes: single pclk at 125 MHz; one instruction issued per write to the instruction register made while idle
// Notes:   data memory and return stack live inside; halt is left by reset or ctrl wake bit
`timescale 1ns/1ns
module mise_core
  import mise_pkg::*;
#(
  parameter int RAM_D = MISE_RAM_D,
  parameter int STK_D = MISE_STK_D
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             halted,
  output logic             wdt_clear
);
  logic [7:0]          acc_r;
  logic [MISE_PC_W-1:0] pc_r;
  logic                z_r, c_r, pd_r, to_r, gie_r;
  logic [7:0]          ram [RAM_D];
  logic [MISE_PC_W-1:0] stk [STK_D];
  logic [2:0]          sp_r;
  logic [7:0]          maddr_r;
  mise_state_t         st_r;
  mise_instr_t         ins;
  mise_res_t           res;
  logic [7:0]          mval;
  logic                acc_ph, wr_ph, rd_ph;
  logic                issue;

  assign acc_ph = ce && psel && penable;
  assign wr_ph  = acc_ph && pwrite;
  assign rd_ph  = acc_ph && !pwrite;
  assign ins    = mise_instr_t'(pwdata[24:0]);
  // instructions only issue while idle; otherwise the write is refused with pslverr
  assign issue  = wr_ph && paddr == MISE_OFF_INSTR && st_r == MISE_S_IDLE;
  assign mval   = (ins.addr < 12'(RAM_D)) ? ram[ins.addr[7:0]] : 8'h00;

  function automatic logic zf(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  always_comb begin
    res = '0;
    res.acc = acc_r;
    res.mem = mval;
    case (mise_op_t'(ins.op))
      MISE_OP_INC: begin
        res.mem = 8'(mval + 8'h01);
        res.mem_we = 1'b1;
        res.z_we = 1'b1;
        res.z = zf(res.mem);
      end
      MISE_OP_INCREMENT_INTO_ACCUMULATOR: begin
        res.acc = 8'(mval + 8'h01);
        res.acc_we = 1'b1;
        res.z_we = 1'b1;
        res.z = zf(res.acc);
      end
      MISE_OP_MOVAM: begin
        res.acc = mval;
        res.acc_we = 1'b1;
      end
      MISE_OP_MOVAX, MISE_OP_RETAX: begin
        res.acc = ins.imm;
        res.acc_we = 1'b1;
      end
      MISE_OP_MOVMA: begin
        res.mem = acc_r;
        res.mem_we = 1'b1;
      end
      MISE_OP_ORAM, MISE_OP_ORAX: begin
        res.acc = acc_r | (ins.op == MISE_OP_ORAM ? mval : ins.imm);
        res.acc_we = 1'b1;
        res.z_we = 1'b1;
        res.z = zf(res.acc);
      end
      MISE_OP_ORM: begin
        res.mem = acc_r | mval;
        res.mem_we = 1'b1;
        res.z_we = 1'b1;
        res.z = zf(res.mem);
      end
      MISE_OP_RL: begin
        res.mem = {mval[6:0], mval[7]};
        res.mem_we = 1'b1;
      end
      MISE_OP_RLA: begin
        res.acc = {mval[6:0], mval[7]};
        res.acc_we = 1'b1;
      end
      MISE_OP_RLC: begin
        res.mem = {mval[6:0], c_r};
        res.mem_we = 1'b1;
        res.c_we = 1'b1;
        res.c = mval[7];
      end
      MISE_OP_ROTATE_LEFT_CARRY_INTO_ACC: begin
        res.acc = {mval[6:0], c_r};
        res.acc_we = 1'b1;
        res.c_we = 1'b1;
        res.c = mval[7];
      end
      MISE_OP_RR: begin
        res.mem = {mval[0], mval[7:1]};
        res.mem_we = 1'b1;
      end
      MISE_OP_RRA: begin
        res.acc = {mval[0], mval[7:1]};
        res.acc_we = 1'b1;
      end
      MISE_OP_RRC: begin
        res.mem = {c_r, mval[7:1]};
        res.mem_we = 1'b1;
        res.c_we = 1'b1;
        res.c = mval[0];
      end
      default: begin
        res.acc = acc_r;
      end
    endcase
  end

  // accumulator and flags; halt keeps all of them as they are
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= MISE_ACC_RST;
      z_r   <= 1'b0;
      c_r   <= 1'b0;
    end else if (issue) begin
      if (res.acc_we) begin
        acc_r <= res.acc;
      end
      if (res.z_we) begin
        z_r <= res.z;
      end
      if (res.c_we) begin
        c_r <= res.c;
      end
    end else if (wr_ph && paddr == MISE_OFF_ACC && st_r == MISE_S_IDLE) begin
      acc_r <= pwdata[7:0];
    end
  end

  // data memory has no reset: contents persist across power-down
  always_ff @(posedge pclk) begin
    if (issue && res.mem_we && ins.addr < 12'(RAM_D)) begin
      ram[ins.addr[7:0]] <= res.mem;
    end else if (wr_ph && paddr == MISE_OFF_MDATA && st_r == MISE_S_IDLE && maddr_r < 8'(RAM_D)) begin
      ram[maddr_r] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_r <= 8'h00;
    end else if (wr_ph && paddr == MISE_OFF_MADDR) begin
      maddr_r <= pwdata[7:0];
    end
  end

  // program counter, stack and sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r  <= MISE_PC_RST;
      sp_r  <= 3'h0;
      st_r  <= MISE_S_IDLE;
      gie_r <= 1'b0;
    end else if (ce) begin
      case (st_r)
        MISE_S_IDLE: begin
          if (issue) begin
            case (mise_op_t'(ins.op))
              MISE_OP_JMP: begin
                pc_r <= ins.addr;
              end
              MISE_OP_CALL: begin
                stk[sp_r[2:0] % 3'(STK_D)] <= 12'(pc_r + 12'h001);
                sp_r <= (sp_r == 3'(STK_D - 1)) ? 3'h0 : 3'(sp_r + 3'h1);
                pc_r <= ins.addr;
              end
              MISE_OP_RET, MISE_OP_RETAX, MISE_OP_INTERRUPT_RETURN: begin
                // the pop lands in the second cycle, giving two machine cycles
                sp_r <= (sp_r == 3'h0) ? 3'(STK_D - 1) : 3'(sp_r - 3'h1);
                st_r <= MISE_S_RET2;
                if (ins.op == MISE_OP_INTERRUPT_RETURN) begin
                  gie_r <= 1'b1;
                end
              end
              MISE_OP_HALT: begin
                pc_r <= 12'(pc_r + 12'h001);
                st_r <= MISE_S_HALT;
              end
              default: begin
                pc_r <= 12'(pc_r + 12'h001);
              end
            endcase
          end else if (wr_ph && paddr == MISE_OFF_CTRL) begin
            gie_r <= pwdata[0];
          end
        end
        MISE_S_RET2: begin
          pc_r <= stk[sp_r];
          st_r <= MISE_S_IDLE;
        end
        MISE_S_HALT: begin
          if (wr_ph && paddr == MISE_OFF_CTRL && pwdata[1]) begin
            st_r <= MISE_S_IDLE;
          end
        end
        default: begin
          st_r <= MISE_S_IDLE;
        end
      endcase
    end
  end

  // watchdog status flags and clear pulse toward the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_r      <= 1'b0;
      to_r      <= 1'b0;
      wdt_clear <= 1'b0;
    end else if (ce) begin
      wdt_clear <= issue && ins.op == MISE_OP_HALT;
      if (issue && ins.op == MISE_OP_HALT) begin
        pd_r <= 1'b1;
        to_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted <= 1'b0;
    end else if (ce) begin
      halted <= (st_r == MISE_S_HALT);
    end
  end

  // apb slave: zero wait states, unmapped accesses and refused instruction writes raise pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          MISE_OFF_INSTR: prdata <= 32'h0000_0000;
          MISE_OFF_ACC:   prdata <= {24'h000000, acc_r};
          MISE_OFF_STAT:  prdata <= {25'h0, st_r != MISE_S_IDLE, st_r == MISE_S_HALT, gie_r, to_r, pd_r, c_r, z_r};
          MISE_OFF_PC:    prdata <= {20'h00000, pc_r};
          MISE_OFF_MADDR: prdata <= {24'h000000, maddr_r};
          MISE_OFF_MDATA: prdata <= (maddr_r < 8'(RAM_D)) ? {24'h000000, ram[maddr_r]} : 32'h0000_0000;
          MISE_OFF_CTRL:  prdata <= {31'h0, gie_r};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
        if (pwrite && paddr == MISE_OFF_INSTR && st_r != MISE_S_IDLE) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  a_jump_target: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_JMP |=> pc_r == $past(ins.addr))
    else $error("jump target not loaded");
  a_jump_flags: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_JMP |=> $stable(z_r) && $stable(c_r))
    else $error("jump changed a flag");
  a_inc_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_INCREMENT_INTO_ACCUMULATOR && mval == 8'hff |=> acc_r == 8'h00 && z_r)
    else $error("increment did not wrap");
  a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
    issue && res.acc_we && res.z_we |=> z_r == (acc_r == 8'h00))
    else $error("zero flag wrong");
  a_halt_flags: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_HALT |=> pd_r && !to_r && wdt_clear ##1 halted)
    else $error("power-down flags wrong");
  a_ret_two: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_RET |=> st_r == MISE_S_RET2 ##1 (st_r == MISE_S_IDLE || !$past(ce)))
    else $error("return not two cycles");
  a_interrupt_return_gie: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_INTERRUPT_RETURN |=> gie_r)
    else $error("global enable not set");
  a_rlc_carry: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_ROTATE_LEFT_CARRY_INTO_ACC |=> c_r == $past(mval[7]) && acc_r[0] == $past(c_r))
    else $error("rotate through carry wrong");
  a_nop_pc: assert property (@(posedge pclk) disable iff (!presetn)
    issue && ins.op == MISE_OP_NOP |=> pc_r == 12'($past(pc_r) + 12'h001) && $stable(acc_r))
    else $error("no-op changed state");
  c_halt: cover property (@(posedge pclk) disable iff (!presetn) issue && ins.op == MISE_OP_HALT);
  c_interrupt_return: cover property (@(posedge pclk) disable iff (!presetn) issue && ins.op == MISE_OP_INTERRUPT_RETURN);
  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) issue && ins.op == MISE_OP_INC && mval == 8'hff);
endmodule

// >>> mise_apb_bfm.sv
// Purpose: apb master standing in for software on the far side of the core
// Assumes: one transfer at a time, launched just after a rising edge
// Notes:   the pready wait is bounded; a timeout is flagged for the bench to act on
`timescale 1ns/1ns
module mise_apb_bfm (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  logic timed_out;
  initial begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    timed_out = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      timed_out = 1'b1;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse so a stale value is never mistaken for a live one
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask
endmodule

// >>> test_mise_core.sv
// Purpose: self-checking bench for the instruction subset execution unit
// Assumes: instructions and state reached only over apb, ce held high
// Notes:   random program from a fixed seed; call depth kept within the stack
`timescale 1ns/1ns
module test_mise_core
  import mise_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, halted, wdt_clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] wdt_n = 32'h0;
  logic [31:0] seed;
  logic [7:0]  acc = 8'h00;
  logic [7:0]  ram [0:159];
  logic [11:0] pc = 12'h000;
  logic [11:0] stk [0:5];
  logic        z = 1'b0, c = 1'b0, pd = 1'b0, gie = 1'b0, hlt = 1'b0;
  int          sp = 0, depth = 0, failures = 0, tests_run = 0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (wdt_clear === 1'b1) wdt_n <= wdt_n + 32'h1;
  mise_core mise_core_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halted(halted), .wdt_clear(wdt_clear));
  mise_apb_bfm mise_apb_bfm_i (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %0s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    mise_apb_bfm_i.xfer(wr, a, wd, rd, err);
    if (mise_apb_bfm_i.timed_out === 1'b1) begin
      failures++;
      summarize();
    end
  endtask
  task automatic rdcmp(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        err;
    bus(1'b0, a, 32'h0, rd, err);
    cmp32(what, exp, rd);
    cmp1("read_err", 1'b0, err);
  endtask
  task automatic check_all(input logic [11:0] a);
    logic [31:0] rd;
    logic        err;
    rdcmp(MISE_OFF_ACC, {24'h0, acc}, "acc");
    rdcmp(MISE_OFF_STAT, {25'h0, hlt, hlt, gie, 1'b0, pd, c, z}, "status");
    rdcmp(MISE_OFF_PC, {20'h0, pc}, "pc");
    bus(1'b1, MISE_OFF_MADDR, {20'h0, a}, rd, err);
    rdcmp(MISE_OFF_MDATA, {24'h0, ram[a]}, "mdata");
  endtask
  task automatic model(input mise_instr_t in);
    logic [7:0] m;
    logic [7:0] r;
    m = ram[in.addr];
    r = m;
    case (in.op)
      MISE_OP_INC, MISE_OP_INCREMENT_INTO_ACCUMULATOR:    r = m + 8'h01;
      MISE_OP_MOVAX, MISE_OP_RETAX: r = in.imm;
      MISE_OP_MOVMA:                r = acc;
      MISE_OP_ORAM, MISE_OP_ORM:    r = acc | m;
      MISE_OP_ORAX:                 r = acc | in.imm;
      MISE_OP_RL, MISE_OP_RLA:      r = {m[6:0], m[7]};
      MISE_OP_RLC, MISE_OP_ROTATE_LEFT_CARRY_INTO_ACC:    r = {m[6:0], c};
      MISE_OP_RR, MISE_OP_RRA:      r = {m[0], m[7:1]};
      MISE_OP_RRC:                  r = {c, m[7:1]};
      default:                      r = m;
    endcase
    if (in.op inside {MISE_OP_INC, MISE_OP_INCREMENT_INTO_ACCUMULATOR, MISE_OP_ORAM, MISE_OP_ORAX, MISE_OP_ORM}) z = (r == 8'h00);
    if (in.op inside {MISE_OP_RLC, MISE_OP_ROTATE_LEFT_CARRY_INTO_ACC}) c = m[7];
    if (in.op == MISE_OP_RRC) c = m[0];
    if (in.op inside {MISE_OP_INC, MISE_OP_MOVMA, MISE_OP_ORM, MISE_OP_RL, MISE_OP_RLC, MISE_OP_RR, MISE_OP_RRC})
      ram[in.addr] = r;
    if (in.op inside {MISE_OP_INCREMENT_INTO_ACCUMULATOR, MISE_OP_MOVAM, MISE_OP_MOVAX, MISE_OP_ORAM, MISE_OP_ORAX, MISE_OP_RETAX,
                      MISE_OP_RLA, MISE_OP_ROTATE_LEFT_CARRY_INTO_ACC, MISE_OP_RRA}) acc = r;
    pc = pc + 12'h001;
    if (in.op == MISE_OP_JMP) pc = in.addr;
    if (in.op == MISE_OP_CALL) begin
      stk[sp] = pc;
      sp = (sp + 1) % 6;
      pc = in.addr;
    end
    if (in.op inside {MISE_OP_RET, MISE_OP_RETAX, MISE_OP_INTERRUPT_RETURN}) begin
      sp = (sp + 5) % 6;
      pc = stk[sp];
    end
    if (in.op == MISE_OP_INTERRUPT_RETURN) gie = 1'b1;
    if (in.op == MISE_OP_HALT) begin
      pd = 1'b1;
      hlt = 1'b1;
    end
  endtask
  task automatic issue(input mise_instr_t in);
    logic [31:0] rd, w;
    logic        err;
    w = wdt_n;
    bus(1'b1, MISE_OFF_INSTR, {7'h00, in}, rd, err);
    cmp1("instr_err", 1'b0, err);
    model(in);
    if (in.op == MISE_OP_HALT) begin
      repeat (3) @(posedge pclk);
      cmp1("halted", 1'b1, halted);
      cmp32("wdt_pulses", w + 32'h1, wdt_n);
      bus(1'b1, MISE_OFF_INSTR, 32'h0, rd, err);
      cmp1("halt_refuse", 1'b1, err);
      check_all(in.addr);
      bus(1'b1, MISE_OFF_CTRL, {30'h0, 1'b1, gie}, rd, err);
      hlt = 1'b0;
    end
    // jump targets reach past the data memory; look at byte 0 then
    check_all((in.addr < 12'd160) ? in.addr : 12'h000);
  endtask
  initial begin
    mise_instr_t in;
    logic [31:0] rd;
    logic        err;
    int          k;
    seed = 32'h0f9d;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 160; i++) begin
      ram[i] = (i == 0) ? 8'hff : 8'($random(seed));
      bus(1'b1, MISE_OFF_MADDR, i, rd, err);
      bus(1'b1, MISE_OFF_MDATA, {24'h0, ram[i]}, rd, err);
    end
    check_all(12'h000);
    bus(1'b0, 12'h01c, 32'h0, rd, err);
    cmp32("unmapped_data", 32'h0, rd);
    cmp1("unmapped_err", 1'b1, err);
    issue('{op: MISE_OP_INC, addr: 12'h000, imm: 8'h00});
    issue('{op: MISE_OP_HALT, addr: 12'h000, imm: 8'h00});
    $display("test directed done");
    for (int n = 0; n < 300; n++) begin
      k = $unsigned($random(seed)) % 22;
      in.op = 5'(k);
      in.addr = 12'($unsigned($random(seed)) % 160);
      in.imm = 8'($random(seed));
      if (in.op inside {MISE_OP_RET, MISE_OP_RETAX, MISE_OP_INTERRUPT_RETURN} && depth == 0) in.op = MISE_OP_CALL;
      else if (in.op == MISE_OP_CALL && depth == 6) in.op = MISE_OP_RET;
      if (in.op inside {MISE_OP_JMP, MISE_OP_CALL}) in.addr = 12'($random(seed));
      if (in.op == MISE_OP_CALL) depth++;
      if (in.op inside {MISE_OP_RET, MISE_OP_RETAX, MISE_OP_INTERRUPT_RETURN}) depth--;
      if (k % 4 == 0) begin
        acc = 8'($random(seed));
        bus(1'b1, MISE_OFF_ACC, {24'h0, acc}, rd, err);
      end
      if (k % 7 == 0) begin
        gie = 1'($random(seed));
        bus(1'b1, MISE_OFF_CTRL, {31'h0, gie}, rd, err);
      end
      issue(in);
    end
    $display("test random done");
    summarize();
  end
endmodule
